// file: spi_flash_pkg.sv
package spi_flash_pkg;

    // Command opcodes
    localparam logic [7:0] OP_READ        = 8'h03;
    localparam logic [7:0] OP_FAST_READ   = 8'h0B;
    localparam logic [7:0] OP_PROGRAM     = 8'h02;
    localparam logic [7:0] OP_ERASE_4K_A  = 8'h20;
    localparam logic [7:0] OP_ERASE_4K_B  = 8'hD7;
    localparam logic [7:0] OP_ERASE_64K   = 8'hD8;
    localparam logic [7:0] OP_CHIP_A      = 8'h60;
    localparam logic [7:0] OP_CHIP_B      = 8'hC7;
    localparam logic [7:0] OP_WR_EN       = 8'h06;
    localparam logic [7:0] OP_WR_DIS      = 8'h04;
    localparam logic [7:0] OP_STAT_RD     = 8'h05;
    localparam logic [7:0] OP_STAT_WR     = 8'h01;
    localparam logic [7:0] OP_JEDEC_ID    = 8'h9F;
    localparam logic [7:0] OP_DEV_ID      = 8'hAB;
    localparam logic [7:0] OP_PWR_DOWN    = 8'hB9;

    // Address and array geometry
    localparam int         ADDR_W         = 18;
    localparam int         PAGE_BITS      = 8;
    localparam int         SMALL_BITS     = 12;
    localparam int         SECT_BITS      = 16;

    // Bit and byte counts within a frame (opcode counts as one)
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [2:0] CNT_MAX        = 3'h7;
    localparam logic [2:0] CNT_OPCODE     = 3'h1;
    localparam logic [2:0] CNT_STAT_WR    = 3'h2;
    localparam logic [2:0] CNT_ADDR_LAST  = 3'h3;
    localparam logic [2:0] CNT_ADDR_DONE  = 3'h4;
    localparam logic [2:0] CNT_FAST_DATA  = 3'h5;

    // Status byte field positions
    localparam int         WEL_POS        = 1;
    localparam int         LOCK_POS       = 7;

    // Reset values
    localparam logic       WEL_RST        = 1'b0;
    localparam logic       PD_RST         = 1'b0;
    localparam logic       MODE_RST       = 1'b0;

endpackage

// file: bit_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser, one stage pair per bit
module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;       // First stage, read only by second stage
    logic [WIDTH-1:0] next_meta;  // Next first stage
    logic [WIDTH-1:0] next_q;     // Next second stage

    // Next values per bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_comb
            begin
                next_meta[g] = rst_i ? 1'b0 : d_i[g];
                next_q[g]    = rst_i ? 1'b0 : meta[g];
            end
        end
    endgenerate

    // Register both stages
    always_ff @(posedge clk_i)
    begin
        meta <= next_meta;
        q_o  <= next_q;
    end

endmodule

// file: spi_flash_command_interface.sv
`timescale 1ns/1ps

// Summary of operation
// - Sample input bits on rising serial clock
// - Shift output bits on falling serial clock
// - Chip select high deselects, ignores clock
// - Protect pin low plus lock refuses rewrites
// - Hold low freezes transfer, resumes intact
// - Bytes framed from select fall, first opcode
// - Clock level at select fall picks mode
// - Only low eighteen address bits decoded
// - Read 03h, fast read 0Bh with dummy
// - Program 02h streams bytes until deselect
// - Decode small, sector and chip erase opcodes
// - Return identification after 9Fh and ABh
// - Lone ABh wakes, B9h powers down
// - Write enable, disable, status read, write
// - Dummy bytes accepted without effect
// - Programming stays within 256-byte page
// - Erase regions aligned to 4K, 64K
// - Read address increments and wraps
// - Status repeats MSB first while clocked
// - Output released while deselected
module spi_flash_command_interface
    import spi_flash_pkg::*;
#(
    parameter logic [7:0] MANUF_ID    = 8'hA5,  // Arbitrary value
    parameter logic [7:0] TYPE_ID     = 8'h3C,  // Arbitrary value
    parameter logic [7:0] CAPACITY_ID = 8'h12,  // Arbitrary value
    parameter logic [7:0] DEVICE_ID   = 8'h5E   // Arbitrary value
) (
    // System clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Serial link pins
    input  wire logic              spi_clk_i,
    input  wire logic              cs_n_i,
    input  wire logic              mosi_i,
    input  wire logic              hold_n_i,
    input  wire logic              wp_n_i,
    output logic                   so_o,
    output logic                   so_oe_o,
    // Array read port, link clock domain
    output logic      [ADDR_W-1:0] mem_addr_o,
    input  wire logic [7:0]        mem_rdata_i,
    // Array status from the program/erase engine
    input  wire logic [7:0]        array_status_i,
    // Device state
    output logic                   write_enable_o,
    output logic                   power_down_o,
    output logic                   spi_mode_o,
    // Erase requests
    output logic                   erase_4k_o,
    output logic                   block_erase_64k_o,
    output logic                   full_array_erase_o,
    output logic      [ADDR_W-1:0] erase_addr_o,
    // Program data requests
    output logic                   program_data_byte_o,
    output logic      [ADDR_W-1:0] prog_addr_o,
    output logic      [7:0]        prog_data_o,
    // Status register rewrite requests
    output logic                   status_write_o,
    output logic                   status_refused_o,
    output logic      [7:0]        status_data_o
);

    // ---------------- Link domain, rising edge ----------------
    logic [2:0]  bit_cnt, next_bit_cnt;      // Bit position within byte
    logic [2:0]  byte_cnt, next_byte_cnt;    // Completed bytes, saturating
    logic [6:0]  shreg, next_shreg;          // Partial byte
    logic [7:0]  opcode, next_opcode;        // First byte of frame
    logic [ADDR_W-1:0] next_mem_addr;        // Next read address
    logic        byte_done, next_byte_done;  // Byte completed on last edge
    logic        req, next_req;              // Byte handshake request
    logic [7:0]  last_byte, next_last_byte;  // Byte held for system side
    logic [7:0]  rx_byte;                    // Byte completing now
    logic        read_data;                  // Read data phase active
    logic        ack_l, pd_l;                // Synchronised to link clock
    logic        ack;                        // Handshake answer, system clock
    logic [7:0]  status_l;                   // Status view on link clock
    logic [7:0]  status_view;                // Status as shown to host

    assign rx_byte   = {shreg, mosi_i};
    assign read_data = (opcode == OP_READ && byte_cnt >= CNT_ADDR_DONE) ||
                       (opcode == OP_FAST_READ && byte_cnt >= CNT_FAST_DATA);

    // Handshake ack, power-down and status into the link domain
    bit_sync #(.WIDTH(10)) u_link_sync (
        .clk_i (spi_clk_i),
        .rst_i (cs_n_i),
        .d_i   ({ack, power_down_o, status_view}),
        .q_o   ({ack_l, pd_l, status_l})
    );

    // Byte framing and address assembly
    always_comb
    begin
        next_bit_cnt   = bit_cnt;
        next_byte_cnt  = byte_cnt;
        next_shreg     = shreg;
        next_opcode    = opcode;
        next_mem_addr  = mem_addr_o;
        next_byte_done = byte_done;
        next_req       = req;
        next_last_byte = last_byte;
        // Edges during hold are ignored entirely
        if (hold_n_i)
        begin
            next_bit_cnt   = bit_cnt + 3'h1;
            next_shreg     = rx_byte[6:0];
            next_byte_done = 1'b0;
            if (bit_cnt == BIT_LAST)
            begin
                next_byte_done = 1'b1;
                next_req       = 1'b1;
                next_last_byte = rx_byte;
                if (byte_cnt != CNT_MAX)
                    next_byte_cnt = byte_cnt + 3'h1;
                // First byte names the command
                if (byte_cnt == 3'h0)
                    next_opcode = rx_byte;
                // Address bytes, top bits fall off the left
                else if (byte_cnt <= CNT_ADDR_LAST)
                    next_mem_addr = {mem_addr_o[ADDR_W-9:0], rx_byte};
                // Sequential read, wraps at the top of the array
                else if (read_data)
                    next_mem_addr = mem_addr_o + 18'h1;
            end
            // Drop request once the system side has seen it
            else if (ack_l)
                next_req = 1'b0;
        end
    end

    // Deselect clears all framing state
    always_ff @(posedge spi_clk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            bit_cnt    <= 3'h0;
            byte_cnt   <= 3'h0;
            shreg      <= 7'h00;
            opcode     <= 8'h00;
            mem_addr_o <= 18'h00000;
            byte_done  <= 1'b0;
            req        <= 1'b0;
        end
        else
        begin
            bit_cnt    <= next_bit_cnt;
            byte_cnt   <= next_byte_cnt;
            shreg      <= next_shreg;
            opcode     <= next_opcode;
            mem_addr_o <= next_mem_addr;
            byte_done  <= next_byte_done;
            req        <= next_req;
        end
    end

    // Held byte survives deselect so the system side can still take it
    always_ff @(posedge spi_clk_i)
    begin
        last_byte <= next_last_byte;
    end

    // ---------------- Link domain, falling edge ----------------
    logic [7:0] next_tx;     // Next output shifter
    logic [7:0] tx;          // Output shifter
    logic       next_drive;  // Next output enable
    logic       load_ok;     // A reply byte is due
    logic [7:0] load_val;    // Reply byte

    // Pick the reply byte for the byte just completed
    always_comb
    begin
        load_ok  = 1'b0;
        load_val = 8'h00;
        case (opcode)
            OP_READ:
            begin
                load_ok  = byte_cnt >= CNT_ADDR_DONE;
                load_val = mem_rdata_i;
            end
            OP_FAST_READ:
            begin
                load_ok  = byte_cnt >= CNT_FAST_DATA;
                load_val = mem_rdata_i;
            end
            OP_STAT_RD:
            begin
                load_ok  = 1'b1;
                load_val = status_l;
            end
            OP_JEDEC_ID:
            begin
                load_ok  = byte_cnt <= CNT_ADDR_LAST;
                load_val = (byte_cnt == 3'h1) ? MANUF_ID :
                           (byte_cnt == 3'h2) ? TYPE_ID : CAPACITY_ID;
            end
            OP_DEV_ID:
            begin
                load_ok  = byte_cnt >= CNT_ADDR_DONE;
                load_val = DEVICE_ID;
            end
            default:
            begin
                load_ok  = 1'b0;
                load_val = 8'h00;
            end
        endcase
        // Powered down, only the wake/ID opcode answers
        if (pd_l && opcode != OP_DEV_ID)
            load_ok = 1'b0;
    end

    // Output shifter: reload on byte boundary, else rotate
    always_comb
    begin
        next_tx    = tx;
        next_drive = so_oe_o;
        if (hold_n_i)
        begin
            if (byte_done && load_ok)
            begin
                next_tx    = load_val;
                next_drive = 1'b1;
            end
            else
                next_tx = {tx[6:0], tx[7]};
        end
    end

    // Falling-edge output registers, released on deselect
    always_ff @(negedge spi_clk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            tx      <= 8'h00;
            so_oe_o <= 1'b0;
            so_o    <= 1'b0;
        end
        else
        begin
            tx      <= next_tx;
            so_oe_o <= next_drive;
            so_o    <= next_tx[7];
        end
    end

    // ---------------- System domain ----------------
    logic       req_s, wp_n_s, sck_s, sel_s;    // Synchronised pins, select active high
    logic       sel_prev, req_prev;             // Edge history
    logic       next_ack;                       // Next handshake answer
    logic [2:0] nbytes, next_nbytes;            // Bytes seen this frame
    logic [7:0] op, next_op;                    // Opcode copy
    logic [ADDR_W-1:0] caddr, next_caddr;       // Address copy
    logic [7:0] sr_data, next_sr_data;          // Second byte copy
    logic [7:0] poff, next_poff;                // Offset within page
    logic       cs_fall, cs_rise, byte_ev;      // Events
    logic       next_wel, next_pd, next_mode;
    logic       next_e4k, next_e64k, next_echip, next_pgm, next_swr, next_sref;
    logic [ADDR_W-1:0] next_eaddr, next_paddr;
    logic [7:0] next_pdata, next_sdata;

    // Select enters inverted so the flush value after reset equals the idle level
    bit_sync #(.WIDTH(4)) u_sys_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({req, wp_n_i, spi_clk_i, !cs_n_i}),
        .q_o   ({req_s, wp_n_s, sck_s, sel_s})
    );

    assign cs_fall     = !sel_prev && sel_s;
    assign cs_rise     = sel_prev && !sel_s;
    assign byte_ev     = req_s && !req_prev;
    assign status_view = {array_status_i[7:2], write_enable_o, array_status_i[0]};

    // Byte intake and command execution at deselect
    always_comb
    begin
        next_ack    = req_s;
        next_nbytes = nbytes;
        next_op     = op;
        next_caddr  = caddr;
        next_sr_data = sr_data;
        next_poff   = poff;
        next_wel    = write_enable_o;
        next_pd     = power_down_o;
        next_mode   = spi_mode_o;
        next_e4k    = 1'b0;
        next_e64k   = 1'b0;
        next_echip  = 1'b0;
        next_pgm    = 1'b0;
        next_swr    = 1'b0;
        next_sref   = 1'b0;
        next_eaddr  = erase_addr_o;
        next_paddr  = prog_addr_o;
        next_pdata  = prog_data_o;
        next_sdata  = status_data_o;
        // New frame: clock level picks the mode
        if (cs_fall)
        begin
            next_nbytes = 3'h0;
            next_mode   = sck_s;
        end
        if (byte_ev)
        begin
            if (nbytes != CNT_MAX)
                next_nbytes = nbytes + 3'h1;
            if (nbytes == 3'h0)
                next_op = last_byte;
            else if (nbytes <= CNT_ADDR_LAST)
                next_caddr = {caddr[ADDR_W-9:0], last_byte};
            if (nbytes == CNT_OPCODE)
                next_sr_data = last_byte;
            if (nbytes == CNT_ADDR_LAST)
                next_poff = last_byte;
            // Program data streams out byte by byte
            if (nbytes >= CNT_ADDR_DONE && op == OP_PROGRAM && write_enable_o && !power_down_o)
            begin
                next_pgm   = 1'b1;
                next_paddr = {caddr[ADDR_W-1:PAGE_BITS], poff};
                next_pdata = last_byte;
                next_poff  = poff + 8'h01;
            end
        end
        // Execute only complete commands; partial ones fall through
        if (cs_rise && nbytes != 3'h0 && (!power_down_o || op == OP_DEV_ID))
        begin
            case (op)
                OP_WR_EN:    next_wel = 1'b1;
                OP_WR_DIS:   next_wel = 1'b0;
                OP_PWR_DOWN: next_pd  = 1'b1;
                OP_DEV_ID:
                    if (nbytes == CNT_OPCODE)
                        next_pd = 1'b0;
                OP_ERASE_4K_A, OP_ERASE_4K_B:
                    if (nbytes >= CNT_ADDR_DONE && write_enable_o)
                    begin
                        next_e4k   = 1'b1;
                        next_eaddr = {caddr[ADDR_W-1:SMALL_BITS], 12'h000};
                        next_wel   = 1'b0;
                    end
                OP_ERASE_64K:
                    if (nbytes >= CNT_ADDR_DONE && write_enable_o)
                    begin
                        next_e64k  = 1'b1;
                        next_eaddr = {caddr[ADDR_W-1:SECT_BITS], 16'h0000};
                        next_wel   = 1'b0;
                    end
                OP_CHIP_A, OP_CHIP_B:
                    if (write_enable_o)
                    begin
                        next_echip = 1'b1;
                        next_eaddr = 18'h00000;
                        next_wel   = 1'b0;
                    end
                OP_STAT_WR:
                    if (nbytes >= CNT_STAT_WR && write_enable_o)
                    begin
                        next_sdata = sr_data;
                        next_wel   = 1'b0;
                        if (!wp_n_s && array_status_i[LOCK_POS])
                            next_sref = 1'b1;
                        else
                            next_swr = 1'b1;
                    end
                OP_PROGRAM:
                    if (nbytes > CNT_ADDR_DONE)
                        next_wel = 1'b0;
                default:
                    next_wel = write_enable_o;
            endcase
        end
    end

    // System-domain registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel_prev <= 1'b0;  req_prev <= 1'b0;  ack <= 1'b0;
            nbytes <= 3'h0;   op <= 8'h00;       caddr <= 18'h00000;
            sr_data <= 8'h00; poff <= 8'h00;
            write_enable_o <= WEL_RST;  power_down_o <= PD_RST;  spi_mode_o <= MODE_RST;
            erase_4k_o <= 1'b0;  block_erase_64k_o <= 1'b0;  full_array_erase_o <= 1'b0;
            program_data_byte_o <= 1'b0;  status_write_o <= 1'b0;  status_refused_o <= 1'b0;
            erase_addr_o <= 18'h00000;  prog_addr_o <= 18'h00000;
            prog_data_o <= 8'h00;  status_data_o <= 8'h00;
        end
        else
        begin
            sel_prev <= sel_s;  req_prev <= req_s;  ack <= next_ack;
            nbytes <= next_nbytes;  op <= next_op;  caddr <= next_caddr;
            sr_data <= next_sr_data;  poff <= next_poff;
            write_enable_o <= next_wel;  power_down_o <= next_pd;  spi_mode_o <= next_mode;
            erase_4k_o <= next_e4k;  block_erase_64k_o <= next_e64k;
            full_array_erase_o <= next_echip;  program_data_byte_o <= next_pgm;
            status_write_o <= next_swr;  status_refused_o <= next_sref;
            erase_addr_o <= next_eaddr;  prog_addr_o <= next_paddr;
            prog_data_o <= next_pdata;  status_data_o <= next_sdata;
        end
    end

    // ---------------- Assertions ----------------
    wel_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_rise && nbytes != 3'h0 && op == OP_WR_EN && !power_down_o |=> write_enable_o)
        else $error("write enable not set");
    wel_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_rise && nbytes != 3'h0 && op == OP_WR_DIS && !power_down_o |=> !write_enable_o)
        else $error("write enable not cleared");
    lock_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_write_o |-> $past(wp_n_s) || !$past(array_status_i[LOCK_POS]))
        else $error("locked status rewrite accepted");
    erase_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (erase_4k_o |-> erase_addr_o[11:0] == 12'h000) and
        (block_erase_64k_o |-> erase_addr_o[15:0] == 16'h0000))
        else $error("erase address misaligned");
    partial_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_rise && nbytes < CNT_ADDR_DONE |=> !erase_4k_o && !block_erase_64k_o)
        else $error("partial erase executed");
    pd_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_rise && nbytes != 3'h0 && op == OP_PWR_DOWN |=> power_down_o [*2])
        else $error("power-down not entered");
    mode_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_fall |=> spi_mode_o == $past(sck_s))
        else $error("mode not taken from clock level");
    page_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        program_data_byte_o |-> prog_addr_o[ADDR_W-1:PAGE_BITS] == caddr[ADDR_W-1:PAGE_BITS])
        else $error("program left its page");
    so_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !sel_s |-> !so_oe_o)
        else $error("output driven while deselected");
    byte_frame_a: assert property (@(posedge spi_clk_i) disable iff (cs_n_i)
        byte_done && hold_n_i |-> bit_cnt == 3'h0 ##1 !byte_done [*7])
        else $error("byte framing broken");

    erase_seen_c:   cover property (@(posedge clk_i) disable iff (rst_i) erase_4k_o);
    program_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) program_data_byte_o);
    swrite_seen_c:  cover property (@(posedge clk_i) disable iff (rst_i) status_write_o);
    mode3_seen_c:   cover property (@(posedge clk_i) disable iff (rst_i) cs_fall && sck_s);

endmodule

// file: flash_array_model.sv
`timescale 1ns/1ps

// Array read side: answers each read address with a byte derived from it
module flash_array_model
    import spi_flash_pkg::*;
(
    // Read port
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    output logic      [7:0]        mem_rdata_o
);
    // Data combines both address ends so a wrap shows up as a new value
    assign mem_rdata_o = mem_addr_i[7:0] + mem_addr_i[17:10];
endmodule

// file: tb.sv
`timescale 1ns/1ps

module tb
    import spi_flash_pkg::*;
;
    logic              clk_i = 0, rst_i = 1;  // System clock and reset
    logic              sclk = 0, cs_n, mosi = 0, hold_n = 1, wp_n = 1;  // Link pins
    logic              so, so_oe, we, pd, mode, e4, e64, ech, pdb, sw, sr;  // Outputs
    logic [ADDR_W-1:0] maddr, eaddr, paddr;  // Addresses
    logic [7:0]        mdat, pdat, sdat, ast = 8'h00;  // Data bytes
    logic [63:0]       rx;  // Reply bits of the last frame
    logic [5:0]        seen;  // Sticky pulse flags
    int                fails = 0, checked = 0, k;
    logic [7:0]        ops [5] = '{8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7};
    logic [5:0]        msk [5] = '{6'h20, 6'h20, 6'h10, 6'h08, 6'h08};
    logic [17:0]       ea [5] = '{18'h2B000, 18'h2B000, 18'h20000, 18'h0, 18'h0};

    spi_flash_command_interface u_spi_flash_command_interface (.clk_i(clk_i), .rst_i(rst_i),
        .spi_clk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .hold_n_i(hold_n), .wp_n_i(wp_n),
        .so_o(so), .so_oe_o(so_oe), .mem_addr_o(maddr), .mem_rdata_i(mdat),
        .array_status_i(ast), .write_enable_o(we), .power_down_o(pd), .spi_mode_o(mode),
        .erase_4k_o(e4), .block_erase_64k_o(e64), .full_array_erase_o(ech),
        .erase_addr_o(eaddr), .program_data_byte_o(pdb), .prog_addr_o(paddr),
        .prog_data_o(pdat), .status_write_o(sw), .status_refused_o(sr), .status_data_o(sdat));
    flash_array_model u_flash_array_model (.mem_addr_i(maddr), .mem_rdata_o(mdat));

    // System clock, 4 ns
    always #2 clk_i = ~clk_i;

    // Collect one-cycle request pulses
    always @(posedge clk_i) seen <= seen | {e4, e64, ech, pdb, sw, sr};

    // One framed exchange; bytes right aligned, MSB first, host samples on rising edges
    // Link clock 12 ns; hold pulled low over two ignored clocks before bit hb is sampled
    task automatic xfer(input logic [63:0] tx, input int n, input logic m3, input int hb = -1);
        int i;
        @(negedge clk_i);
        seen = 6'h00;
        sclk = m3;
        #13 cs_n = 0;
        #13;
        for (i = 8 * n - 1; i >= 0; i--)
        begin
            sclk = 0;
            mosi = tx[i];
            if (i == hb)
            begin
                #3 hold_n = 0;
                repeat (2)
                begin
                    #6 sclk = 1;
                    #6 sclk = 0;
                end
                #3 hold_n = 1;
            end
            #6 sclk = 1;
            rx[i] = so;
            #6;
        end
        sclk = m3;
        #13 cs_n = 1;
        repeat (8) @(negedge clk_i);
    endtask

    // Compare one result
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #200000;
        fails++;
        test_done();
    end

    initial
    begin
        // Rising select gives the link logic its first clear
        @(negedge clk_i) cs_n = 1;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i) rst_i = 0;
        repeat (4) @(posedge clk_i);
        xfer(64'h06, 1, 0);
        chk("write_enable", 1, we);
        chk("spi_mode", 0, mode);
        for (k = 0; k < 5; k++)
        begin
            xfer(64'h06, 1, 0);
            xfer({ops[k], 24'h3ABCDE} >> ((k > 2) ? 24 : 0), (k > 2) ? 1 : 4, 0);
            chk("erase_flags", msk[k], seen);
            chk("erase_addr", ea[k], eaddr);
        end
        $display("erase test done");
        xfer(64'h06, 1, 1);
        chk("spi_mode", 1, mode);
        xfer(64'h203ABC, 3, 0);
        chk("partial_flags", 0, seen);
        xfer(64'h020412FEAA55C3, 7, 0);
        chk("prog_flags", 6'h04, seen);
        chk("prog_addr", 18'h01200, paddr);
        chk("prog_data", 8'hC3, pdat);
        $display("frame and program test done");
        @(negedge clk_i) ast = 8'h80;
        xfer(64'h06, 1, 0);
        xfer(64'h050000, 3, 0);
        chk("status_bytes", 16'h8282, rx[15:0]);
        chk("so_enable", 0, so_oe);
        @(negedge clk_i) wp_n = 0;
        xfer(64'h013C, 2, 0);
        chk("status_flags", 6'h01, seen);
        chk("status_data", 8'h3C, sdat);
        @(negedge clk_i) wp_n = 1;
        xfer(64'h06, 1, 0);
        xfer(64'h015A, 2, 0);
        chk("status_flags", 6'h02, seen);
        xfer(64'h06, 1, 0);
        xfer(64'h04, 1, 0);
        chk("write_enable", 0, we);
        $display("status test done");
        xfer(64'h03FFFFFF0000, 6, 0);
        chk("read_bytes", 16'hFE00, rx[15:0]);
        xfer(64'h0B000010A700, 6, 0);
        chk("fast_read", 8'h10, rx[7:0]);
        xfer(64'h9F000000, 4, 0);
        chk("ident", 24'hA53C12, rx[23:0]);
        xfer(64'h9F000000, 4, 0, 12);
        chk("hold_ident", 24'hA53C12, rx[23:0]);
        xfer(64'hAB00000000, 5, 0);
        chk("device_id", 8'h5E, rx[7:0]);
        xfer(64'hB9, 1, 0);
        chk("power_down", 1, pd);
        xfer(64'h9F000000, 4, 0);
        chk("pd_silent", 0, rx[23:0]);
        xfer(64'hAB, 1, 0);
        chk("power_down", 0, pd);
        $display("read and id test done");
        test_done();
    end
endmodule
